// File: design/sic_crc_i2s.sv
// Operation
// RQ1 - With checksum enabled, accumulate CRC over received bits into rx register.
// RQ2 - With checksum enabled, accumulate CRC over transmitted bits into tx register.
// RQ3 - Rx CRC is 8-bit in low byte for 8-bit frames, else 16-bit.
// RQ4 - Tx CRC is 8-bit in low byte for 8-bit frames, else 16-bit.
// RQ5 - Rx CRC updates every received bit; reads mid-transfer show partial value.
// RQ6 - Tx CRC updates every transmitted bit; reads mid-transfer show partial value.
// RQ7 - Tx CRC follows bit order, so LSB-first and MSB-first values differ.
// RQ8 - Both accumulators clear on checksum enable set or peripheral reset.
// RQ9 - Bit 11 picks SPI or I2S, changed only when disabled; bit 10 enables I2S.
// RQ10 - Role field: slave tx, slave rx, master tx, master rx.
// RQ11 - Frame sync bit selects short or long sync, only under PCM standard.
// RQ12 - Standard field: Philips, MSB-justified, LSB-justified, PCM.
// RQ13 - Clock polarity bit sets idle level of audio serial clock.
// RQ14 - Sample width field: 16, 24, 32 bits, 11 reserved.
// RQ15 - Slot width 16 or 32; software keeps slot no shorter than sample.
// RQ16 - Software changes I2S configuration fields only while I2S is disabled.
// RQ17 - In SPI mode the I2S configuration fields have no effect.
// RQ18 - CRC uses the polynomial register, reset value 0007h.
// RQ19 - Mismatch flag sets when rx CRC differs from received CRC word; write 0 clears.
// RQ20 - 8-bit frames use only the low byte; upper byte reads zero.
// RQ21 - Each accumulator is a serial LFSR, one bit per clock, starting from zero.
//
// Implementation choice: the AHB-Lite register port.
module sic_crc_i2s (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link taps
  input  wire logic        linkClk,
  input  wire logic        rxBit,
  input  wire logic        txBit,
  // Data path handshakes
  input  wire logic        peripheralReset,
  input  wire logic        transferActive,
  input  wire logic        crcPhase,
  input  wire logic        crcCheck,
  input  wire logic [15:0] rxCrcWord,
  // Configuration outputs
  output logic             frameWide,
  output logic             lsbFirstSelect,
  output logic             audioActive,
  output logic [1:0]       audioRoleSelect,
  output logic [1:0]       audioStandardSelect,
  output logic             frameSyncStyle,
  output logic             clockIdlePolarity,
  output logic [1:0]       sampleWidth,
  output logic             slotWidth,
  output logic             checksumMismatchFlag
);

  logic [2:0]  control0;
  logic [15:0] checksumPolynomial;
  logic [11:0] i2sControl;
  logic [15:0] rxChecksum;
  logic [15:0] txChecksum;
  logic [15:0] rxSnapshot;
  logic        crcPhaseDly;
  logic        enableDly;
  logic        wrPending;
  logic [7:0]  wrAddr;
  logic        checksumEnable;
  logic        audioModeSelect;
  logic        audioEnable;
  logic        crcRun;
  logic        bitEdge;
  logic        crcClear;
  logic [31:0] next_hrdata;
  logic [15:0] next_rxChecksum;
  logic [15:0] next_txChecksum;
  logic        addrValid;
  logic        wrHit;

  // Three-stage synchronisers for clock and data taps
  logic [2:0] clkSync;
  logic [2:0] rxSync;
  logic [2:0] txSync;
  logic       clkLevel;
  logic       clkLevelDly;
  logic       rxLevel;
  logic       txLevel;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign checksumEnable  = control0[sic_pkg::CTL_CRC_EN_BIT];
  assign frameWide       = control0[sic_pkg::CTL_WIDE_BIT];
  assign lsbFirstSelect  = control0[sic_pkg::CTL_LSB_BIT];
  assign audioModeSelect = i2sControl[sic_pkg::I2S_SEL_BIT];
  assign audioEnable     = i2sControl[sic_pkg::I2S_EN_BIT];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkSync <= 3'h0;
      rxSync  <= 3'h0;
      txSync  <= 3'h0;
    end else begin
      clkSync <= {clkSync[1:0], linkClk};
      rxSync  <= {rxSync[1:0], rxBit};
      txSync  <= {txSync[1:0], txBit};
    end
  end

  // A level counts once stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkLevel    <= 1'b0;
      clkLevelDly <= 1'b0;
      rxLevel     <= 1'b0;
      txLevel     <= 1'b0;
    end else begin
      if (clkSync[1] == clkSync[2]) begin
        clkLevel <= clkSync[2];
      end
      if (rxSync[1] == rxSync[2]) begin
        rxLevel <= rxSync[2];
      end
      if (txSync[1] == txSync[2]) begin
        txLevel <= txSync[2];
      end
      clkLevelDly <= clkLevel;
    end
  end

  // Bits are taken on the rising edge of the link clock
  assign bitEdge = clkLevel && !clkLevelDly;
  // CRC runs only in SPI mode while a transfer is active
  assign crcRun  = checksumEnable && !audioModeSelect && transferActive;
  // Clear when enable goes from 0 to 1 or on peripheral reset
  assign crcClear = (checksumEnable && !enableDly) || peripheralReset; // RQ8

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic        din,
                                           input logic        wide,
                                           input logic [15:0] poly);
    logic        fb;
    logic [15:0] shifted;
    fb      = din ^ (wide ? crc[15] : crc[7]);
    shifted = {crc[14:0], 1'b0};
    if (fb) begin
      shifted = shifted ^ poly; // RQ18
    end
    if (!wide) begin
      shifted = {8'h00, shifted[7:0]}; // RQ3 RQ4
    end
    return shifted;
  endfunction : crc_step

  // Bits arrive in frame order, so the bit-order setting shapes the result
  assign next_rxChecksum = crc_step(rxChecksum, rxLevel, frameWide, checksumPolynomial); // RQ21
  assign next_txChecksum = crc_step(txChecksum, txLevel, frameWide, checksumPolynomial); // RQ7

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxChecksum <= sic_pkg::CRC_RESET;
    end else if (crcClear) begin
      rxChecksum <= sic_pkg::CRC_RESET; // RQ8
    end else if (crcRun && bitEdge) begin
      rxChecksum <= next_rxChecksum; // RQ1 RQ5
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txChecksum <= sic_pkg::CRC_RESET;
    end else if (crcClear) begin
      txChecksum <= sic_pkg::CRC_RESET; // RQ8
    end else if (crcRun && bitEdge) begin
      txChecksum <= next_txChecksum; // RQ2 RQ6
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enableDly <= 1'b0;
    end else begin
      enableDly <= checksumEnable;
    end
  end

  // Freeze the data CRC as the CRC word begins to arrive
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crcPhaseDly <= 1'b0;
      rxSnapshot  <= sic_pkg::CRC_RESET;
    end else begin
      crcPhaseDly <= crcPhase;
      if (crcPhase && !crcPhaseDly) begin
        rxSnapshot <= rxChecksum;
      end
    end
  end

  // AHB address phase
  assign addrValid = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      wrPending <= addrValid && hwrite;
      if (addrValid) begin
        wrAddr <= haddr[7:0];
      end
    end
  end

  assign wrHit = wrPending;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      control0           <= sic_pkg::CTL0_RESET;
      checksumPolynomial <= sic_pkg::POLY_RESET; // RQ18
    end else if (wrHit) begin
      if (wrAddr == sic_pkg::ADDR_CONTROL0) begin
        control0 <= hwdata[2:0];
      end
      if (wrAddr == sic_pkg::ADDR_POLY) begin
        checksumPolynomial <= hwdata[15:0];
      end
    end
  end

  // Configuration and mode bit hold while I2S runs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      i2sControl <= sic_pkg::I2S_CTL_RESET;
    end else if (wrHit && wrAddr == sic_pkg::ADDR_I2S_CTL) begin
      i2sControl[sic_pkg::I2S_EN_BIT] <= hwdata[sic_pkg::I2S_EN_BIT]; // RQ9
      if (!audioEnable) begin
        i2sControl[sic_pkg::I2S_SEL_BIT] <= hwdata[sic_pkg::I2S_SEL_BIT]; // RQ9
        i2sControl[7:0] <= hwdata[7:0] & sic_pkg::I2S_CFG_MASK[7:0]; // RQ16
        i2sControl[9:8] <= hwdata[9:8]; // RQ10
      end
    end
  end

  // Mismatch: set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      checksumMismatchFlag <= 1'b0;
    end else if (crcCheck && checksumEnable &&
                 (rxCrcWord & (frameWide ? 16'hffff : 16'h00ff)) != rxSnapshot) begin
      checksumMismatchFlag <= 1'b1; // RQ19
    end else if (wrHit && wrAddr == sic_pkg::ADDR_STATUS &&
                 !hwdata[sic_pkg::STAT_MISMATCH_BIT]) begin
      checksumMismatchFlag <= 1'b0; // RQ19
    end
  end

  // Audio configuration is decoded only in I2S mode
  always_comb begin
    audioActive         = 1'b0;
    audioRoleSelect     = 2'b00;
    audioStandardSelect = 2'b00;
    frameSyncStyle      = 1'b0;
    clockIdlePolarity   = 1'b0;
    sampleWidth         = 2'b00;
    slotWidth           = 1'b0;
    if (audioModeSelect) begin // RQ17
      audioActive         = audioEnable; // RQ9
      audioRoleSelect     = i2sControl[sic_pkg::I2S_ROLE_LSB +: 2]; // RQ10
      audioStandardSelect = i2sControl[sic_pkg::I2S_STD_LSB +: 2]; // RQ12
      clockIdlePolarity   = i2sControl[sic_pkg::I2S_CLOCK_IDLE_POLARITY_BIT]; // RQ13
      sampleWidth         = i2sControl[sic_pkg::I2S_WIDTH_LSB +: 2]; // RQ14
      slotWidth           = i2sControl[sic_pkg::I2S_SLOT_BIT]; // RQ15
      if (i2sControl[sic_pkg::I2S_STD_LSB +: 2] == sic_pkg::STD_PCM) begin
        frameSyncStyle = i2sControl[sic_pkg::I2S_SYNC_BIT]; // RQ11
      end
    end
  end

  // Read data is prepared in the address phase and stands in the data phase
  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr[7:0])
      sic_pkg::ADDR_CONTROL0: next_hrdata = {29'h0, control0};
      sic_pkg::ADDR_STATUS:   next_hrdata = {27'h0, checksumMismatchFlag, 4'h0};
      sic_pkg::ADDR_POLY:     next_hrdata = {16'h0, checksumPolynomial};
      sic_pkg::ADDR_RX_CRC:   next_hrdata = {16'h0, frameWide ? rxChecksum[15:8] : 8'h00,
                                             rxChecksum[7:0]}; // RQ20
      sic_pkg::ADDR_TX_CRC:   next_hrdata = {16'h0, frameWide ? txChecksum[15:8] : 8'h00,
                                             txChecksum[7:0]}; // RQ20
      sic_pkg::ADDR_I2S_CTL:  next_hrdata = {20'h0, i2sControl};
      default:                next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrValid && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

endmodule : sic_crc_i2s

// File: design/sic_pkg.sv
package sic_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL0  = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_POLY      = 8'h10;
  localparam logic [7:0] ADDR_RX_CRC    = 8'h14;
  localparam logic [7:0] ADDR_TX_CRC    = 8'h18;
  localparam logic [7:0] ADDR_I2S_CTL   = 8'h1c;

  // serial_control0 fields
  localparam int CTL_CRC_EN_BIT  = 0;
  localparam int CTL_WIDE_BIT    = 1;
  localparam int CTL_LSB_BIT     = 2;

  // Status fields
  localparam int STAT_MISMATCH_BIT = 4;

  // i2s_control fields
  localparam int I2S_SEL_BIT     = 11;
  localparam int I2S_EN_BIT      = 10;
  localparam int I2S_ROLE_LSB    = 8;
  localparam int I2S_SYNC_BIT    = 7;
  localparam int I2S_STD_LSB     = 4;
  localparam int I2S_CLOCK_IDLE_POLARITY_BIT    = 3;
  localparam int I2S_WIDTH_LSB   = 1;
  localparam int I2S_SLOT_BIT    = 0;
  localparam logic [11:0] I2S_CFG_MASK = 12'h0bf;

  // Reset values
  localparam logic [15:0] POLY_RESET    = 16'h0007;
  localparam logic [11:0] I2S_CTL_RESET = 12'h000;
  localparam logic [2:0]  CTL0_RESET    = 3'h0;
  localparam logic [15:0] CRC_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    ROLE_SLAVE_TX  = 2'b00,
    ROLE_SLAVE_RX  = 2'b01,
    ROLE_MASTER_TX = 2'b10,
    ROLE_MASTER_RX = 2'b11
  } sic_role_type;

  typedef enum logic [1:0] {
    STD_PHILIPS = 2'b00,
    STD_MSB     = 2'b01,
    STD_LSB     = 2'b10,
    STD_PCM     = 2'b11
  } sic_std_type;

endpackage : sic_pkg

// File: verification/sic_link_model.sv
module sic_link_model (
  // Serial link taps
  output logic linkClk,
  output logic rxBit,
  output logic txBit,
  output logic transferActive
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    linkClk        = 1'b0;
    rxBit          = 1'b0;
    txBit          = 1'b1;
    transferActive = 1'b0;
  end

  // Sends n bits, first bit on the wire is the MSB unless lsb is set
  task automatic send(input logic [15:0] rd, input logic [15:0] td, input int n, input logic lsb);
    int k;
    #1 transferActive = 1'b1;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      rxBit = rd[k];
      txBit = td[k];
      #80 linkClk = 1'b1;
      #80 linkClk = 1'b0;
    end
    // Released data lines show the inverse, not a held value
    #80 rxBit = ~rxBit;
    txBit          = ~txBit;
    transferActive = 1'b0;
  endtask : send
endmodule : sic_link_model

// File: verification/sic_crc_i2s_props.sv
module sic_crc_i2s_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Link side and configuration
  input wire logic        crcCheck,
  input wire logic        frameWide,
  input wire logic        audioActive,
  input wire logic [1:0]  audioRoleSelect,
  input wire logic [1:0]  audioStandardSelect,
  input wire logic        frameSyncStyle,
  input wire logic        clockIdlePolarity,
  input wire logic [1:0]  sampleWidth,
  input wire logic        slotWidth,
  input wire logic        checksumMismatchFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic taken;
  assign taken = hsel && htrans[1] && hready;

  sequence s_rd_crc;
    taken && !hwrite && !frameWide &&
      (haddr[7:0] == sic_pkg::ADDR_RX_CRC || haddr[7:0] == sic_pkg::ADDR_TX_CRC);
  endsequence
  sequence s_wr_clear;
    taken && hwrite && haddr[7:0] == sic_pkg::ADDR_STATUS ##1 !hwdata[4] && !crcCheck;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_narrow_crc: assert property (s_rd_crc |=> hrdata[15:8] == 8'h00)
    else $error("narrow checksum upper byte not zero");
  a_flag_clear: assert property (s_wr_clear |=> !checksumMismatchFlag)
    else $error("mismatch flag not cleared by zero write");
  a_flag_cause: assert property ($rose(checksumMismatchFlag) |-> $past(crcCheck))
    else $error("mismatch flag set without a check");
  a_sync_pcm: assert property (frameSyncStyle |-> audioStandardSelect == 2'b11)
    else $error("frame sync style outside pcm");
  a_cfg_frozen: assert property (audioActive && $past(audioActive) |->
    $stable({audioRoleSelect, audioStandardSelect, frameSyncStyle, clockIdlePolarity,
             sampleWidth, slotWidth}))
    else $error("audio setup changed while enabled");
endmodule : sic_crc_i2s_chk

bind sic_crc_i2s sic_crc_i2s_chk u_chk (.*);

// File: verification/tb.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, linkClk, rxBit, txBit;
  logic        transferActive, peripheralReset, crcPhase, crcCheck, frameWide;
  logic        lsbFirstSelect, audioActive, frameSyncStyle, clockIdlePolarity;
  logic        slotWidth, checksumMismatchFlag;
  logic [1:0]  htrans, audioRoleSelect, audioStandardSelect, sampleWidth;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] rxCrcWord, rxd, txd, er, et, poly;
  logic [11:0] w;
  logic [7:0]  ra [7] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
  int          bad_count, checks, seed, n, x;

  sic_crc_i2s DUT (.*, .hready(hreadyout), .hsize(3'h2));
  sic_link_model u_link (.*);

  always #5 mclk = ~mclk;

  function automatic logic [15:0] step(logic [15:0] c, logic b, logic wd, logic [15:0] p);
    logic fb;
    fb = b ^ (wd ? c[15] : c[7]);
    c = (c << 1) ^ (fb ? p : 16'h0000);
    return wd ? c : {8'h00, c[7:0]};
  endfunction : step

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (!hreadyout) @(posedge mclk);
    q = hrdata;
  endtask : bus

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    #400us;
    bad_count++;
    end_sim();
  end

  initial begin
    seed = 32'h7d80;
    {mclk, nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {peripheralReset, crcPhase, crcCheck, rxCrcWord} = '0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (ra[i]) begin
      bus(ra[i], 1'b0, 32'h0);
      `CHK(q, (ra[i] == sic_pkg::ADDR_POLY) ? {16'h0, sic_pkg::POLY_RESET} : 32'h0)
    end
    for (int i = 0; i < 4; i++) begin
      w = 12'($random(seed));
      w[11:8] = {2'b10, i[1:0]};
      // Sync bit set under a non-PCM and the PCM standard alike
      w[7] = w[7] | (i >= 2);
      w[5:4] = i[1:0];
      w[0] = w[0] | (w[2:1] != 2'b00);
      bus(sic_pkg::ADDR_I2S_CTL, 1'b1, {20'h0, w});
      bus(sic_pkg::ADDR_I2S_CTL, 1'b0, 32'h0);
      `CHK(q, {20'h0, w & 12'hfbf})
      `CHK({audioRoleSelect, audioStandardSelect}, {w[9:8], w[5:4]})
      `CHK({clockIdlePolarity, sampleWidth, slotWidth}, w[3:0])
      `CHK(frameSyncStyle, w[7] & (i == 3))
      bus(sic_pkg::ADDR_I2S_CTL, 1'b1, {20'h0, w | 12'h400});
      bus(sic_pkg::ADDR_I2S_CTL, 1'b1, {20'h0, ~w | 12'h400});
      // Let the write settle before looking at the decoded outputs
      @(posedge mclk);
      `CHK({audioActive, audioRoleSelect, sampleWidth}, {1'b1, w[9:8], w[2:1]})
      bus(sic_pkg::ADDR_I2S_CTL, 1'b1, 32'h0);
    end
    w = (12'($random(seed)) & 12'h3ff) | 12'h0b9;
    bus(sic_pkg::ADDR_I2S_CTL, 1'b1, {20'h0, w});
    @(posedge mclk);
    `CHK({audioActive, audioRoleSelect, audioStandardSelect}, 5'h00)
    `CHK({frameSyncStyle, clockIdlePolarity, sampleWidth, slotWidth}, 5'h00)
    for (int k = 0; k < 4; k++) begin
      poly = 16'($random(seed));
      poly[0] = 1'b1;
      bus(sic_pkg::ADDR_POLY, 1'b1, {16'h0, poly});
      bus(sic_pkg::ADDR_CONTROL0, 1'b1, 32'h0);
      bus(sic_pkg::ADDR_CONTROL0, 1'b1, {29'h0, k[1], k[0], 1'b1});
      @(posedge mclk);
      `CHK({lsbFirstSelect, frameWide}, k[1:0])
      rxd = 16'($random(seed));
      txd = 16'($random(seed));
      n = k[0] ? 16 : 8;
      er = 16'h0000;
      et = 16'h0000;
      for (int j = 0; j < n; j++) begin
        x = k[1] ? j : n - 1 - j;
        er = step(er, rxd[x], k[0], poly);
        et = step(et, txd[x], k[0], poly);
      end
      u_link.send(rxd, txd, n, k[1]);
      @(posedge mclk);
      bus(sic_pkg::ADDR_RX_CRC, 1'b0, 32'h0);
      `CHK(q, {16'h0, er})
      bus(sic_pkg::ADDR_TX_CRC, 1'b0, 32'h0);
      `CHK(q, {16'h0, et})
    end
    for (int m = 0; m < 2; m++) begin
      crcPhase <= 1'b1;
      @(posedge mclk);
      rxCrcWord <= er ^ m[15:0] ^ 16'h0001;
      crcCheck  <= 1'b1;
      @(posedge mclk);
      crcCheck <= 1'b0;
      crcPhase <= 1'b0;
      @(posedge mclk);
      bus(sic_pkg::ADDR_STATUS, 1'b0, 32'h0);
      `CHK(q[4], ~m[0])
      bus(sic_pkg::ADDR_STATUS, 1'b1, 32'h0);
    end
    peripheralReset <= 1'b1;
    @(posedge mclk);
    peripheralReset <= 1'b0;
    bus(sic_pkg::ADDR_RX_CRC, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    bus(sic_pkg::ADDR_TX_CRC, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    end_sim();
  end
endmodule : tb
